// ==== hdl/uct_pkg.sv ====
// How it works
// - Double speed in asynchronous mode divides the baud tick by 8, not 16.
// - Double speed makes the receiver take 8 samples per bit, not 16.
// - Slave transfer clock passes a synchroniser then an edge detector.
// - Synchronous master drives the transfer clock; slave takes it as input.
// - Polarity zero: change on rising, sample on falling; set: the reverse.
// - Frame: low start, 5 to 9 data LSB first, optional parity, 1-2 high stops.
// - Parity bit sits after the last data bit, before the first stop.
// - After a frame, next frame follows at once or line idles high.
// - Size and parity settings are shared by receiver and transmitter; the stop setting is used by the transmitter only.
// - Receiver ignores a second stop; frame error only if first stop is low.
// - Parity is XOR of data bits, inverted for odd parity.
// - Transmit enable hands the serial output pin to the transmitter.
// - Synchronous master mode takes over the transfer clock pin, transmitter enabled or not.
// - A data write loads the transmit buffer and starts transmission.
// - Buffer moves to shifter when idle or right after the last stop bit.
// - Loaded shifter sends one frame at baud, double-speed or external rate.
// - Unused upper data bits are ignored for sizes below eight.
// - Baud down-counter reloads at zero or on low-byte write; it ticks only at zero.
// - Size code 7 means 9 bits; ninth bit set before the low byte write.
// - Transmit-empty is set while the buffer is empty, cleared by a write.
// - Transmit-complete sets when the frame is out and nothing waits.
package uct_pkg;

  // Widths and depths
  localparam int unsigned UCT_DIV_W = 12;
  localparam int unsigned UCT_FIFO_DEPTH = 32;

  // Sample counter wrap and mid points
  localparam logic [3:0] UCT_LAST_NORMAL = 4'hf;
  localparam logic [3:0] UCT_LAST_DOUBLE = 4'h7;
  localparam logic [3:0] UCT_MID_NORMAL = 4'h7;
  localparam logic [3:0] UCT_MID_DOUBLE = 4'h3;

  // Frame format encodings
  localparam logic [2:0] UCT_CSZ_NINE = 3'h7;
  localparam logic [3:0] UCT_BITS_BASE = 4'h5;
  localparam logic [3:0] UCT_BITS_EIGHT = 4'h8;
  localparam logic [3:0] UCT_BITS_MAX = 4'h9;

  // Transmitter and receiver states, one-hot
  typedef enum logic [4:0] {
    UCT_TX_IDLE = 5'h01, UCT_TX_START = 5'h02, UCT_TX_DATA = 5'h04,
    UCT_TX_PAR = 5'h08, UCT_TX_STOP = 5'h10
  } uct_tx_e;
  typedef enum logic [4:0] {
    UCT_RX_IDLE = 5'h01, UCT_RX_START = 5'h02, UCT_RX_DATA = 5'h04,
    UCT_RX_PAR = 5'h08, UCT_RX_STOP = 5'h10
  } uct_rx_e;

  // One buffered character
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } uct_word_s;

  // Whole state of the core
  typedef struct packed {
    logic [UCT_DIV_W-1:0] baud_cnt;
    logic xck;
    logic [2:0] xsync;
    logic [1:0] rxsync;
    logic [3:0] tx_div;
    uct_tx_e tx_st;
    logic [8:0] tx_sh;
    logic tx_par;
    logic [3:0] tx_cnt;
    logic tx_stop2;
    logic txd;
    logic tx_done;
    uct_rx_e rx_st;
    logic [3:0] rx_scnt;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic rx_par;
    logic [8:0] rx_data;
    logic rx_valid;
    logic rx_fe;
    logic rx_pe;
  } uct_core_s;

  // Reset values: line idles high, both machines idle
  localparam logic UCT_LINE_IDLE = 1'b1;
  localparam uct_core_s UCT_CORE_RST = '{tx_st: UCT_TX_IDLE, rx_st: UCT_RX_IDLE,
                                         txd: UCT_LINE_IDLE, default: '0};

endpackage : uct_pkg

// ==== hdl/uct_core.sv ====
`timescale 1ns/10ps

// Transmit buffer, flip-flop storage
module uct_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LASTP = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } uct_fifo_s;

  uct_fifo_s s_q, s_d;
  logic push, pop;

  assign o_in_ready = (s_q.cnt != FULL);
  assign o_out_valid = (s_q.cnt != '0);
  assign o_out_data = s_q.mem[s_q.rp];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // Pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = i_in_data;
      s_d.wp = (s_q.wp == LASTP) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == LASTP) ? '0 : s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : uct_fifo

// Clock generation, transmitter and receiver
module uct_top import uct_pkg::*; #(
  parameter int unsigned FIFO_DEPTH = UCT_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Mode and format settings
  input wire logic i_double_speed,
  input wire logic i_sync_mode,
  input wire logic i_xck_master,
  input wire logic i_clock_polarity,
  input wire logic [2:0] i_char_size,
  input wire logic [1:0] i_parity_mode,
  input wire logic i_stop_bits,
  input wire logic i_tx_enable,
  input wire logic i_rx_enable,
  // Baud divisor
  input wire logic [UCT_DIV_W-1:0] i_baud_divisor,
  input wire logic i_baud_lo_wr,
  // Transmit data buffer
  input wire logic i_data_wr,
  input wire logic [7:0] i_data,
  input wire logic i_tx_ninth,
  output logic o_data_ready,
  output logic o_tx_empty,
  output logic o_tx_complete,
  input wire logic i_tx_complete_clr,
  // Received character
  output logic [8:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_frame_err,
  output logic o_rx_parity_err,
  // Serial pins
  output logic o_serial_out,
  output logic o_serial_out_oe,
  input wire logic i_serial_in,
  input wire logic i_xfer_clk_in,
  output logic o_xfer_clk_out,
  output logic o_xfer_clk_oe
);

  uct_core_s s_q, s_d;
  uct_word_s f_word;
  logic f_valid, f_pop;

  // Data bits per frame from the size code
  function automatic logic [3:0] char_bits(input logic [2:0] csz);
    if (csz == UCT_CSZ_NINE) begin
      return UCT_BITS_MAX;
    end else if (!csz[2]) begin
      return UCT_BITS_BASE + {2'h0, csz[1:0]};
    end
    return UCT_BITS_EIGHT;
  endfunction : char_bits

  // Keep only the low n bits of a character
  function automatic logic [8:0] keep_low(input logic [8:0] w, input logic [3:0] n);
    logic [9:0] m;
    m = (10'h001 << n) - 10'h001;
    return w & m[8:0];
  endfunction : keep_low

  // Writes enter the buffer; full buffer stalls the writer
  uct_fifo #(
    .W($bits(uct_word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_buf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_in_valid(i_data_wr),
    .o_in_ready(o_data_ready),
    .i_in_data({i_tx_ninth, i_data}),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data(f_word)
  );

  logic baud_tick, async_mode, dbl, slave, master;
  logic rise, fall, chg_edge, smp_edge, tx_tick, rx_evt;
  logic [3:0] last_smp, mid_smp, nbits;
  logic pen, podd;
  logic [8:0] ld_word;
  logic done_set;

  // Mode decode shared by both directions
  always_comb begin
    async_mode = ~i_sync_mode;
    dbl = i_double_speed & async_mode;
    master = i_sync_mode & i_xck_master;
    slave = i_sync_mode & ~i_xck_master;
    baud_tick = (s_q.baud_cnt == '0);
    last_smp = dbl ? UCT_LAST_DOUBLE : UCT_LAST_NORMAL;
    mid_smp = dbl ? UCT_MID_DOUBLE : UCT_MID_NORMAL;
    nbits = char_bits(i_char_size);
    pen = i_parity_mode[1];
    podd = i_parity_mode[0];
    // Slave edges come only from the synchronised copy, never the first flop
    rise = slave ? (s_q.xsync[1] & ~s_q.xsync[2]) : (master & baud_tick & ~s_q.xck);
    fall = slave ? (~s_q.xsync[1] & s_q.xsync[2]) : (master & baud_tick & s_q.xck);
    chg_edge = i_clock_polarity ? fall : rise;
    smp_edge = i_clock_polarity ? rise : fall;
    tx_tick = async_mode ? (baud_tick && s_q.tx_div == last_smp) : chg_edge;
    rx_evt = async_mode ? (baud_tick && s_q.rx_scnt == mid_smp && s_q.rx_st != UCT_RX_IDLE)
                        : smp_edge;
    ld_word = keep_low({f_word.ninth, f_word.data}, nbits);
    f_pop = f_valid && tx_tick &&
            (s_q.tx_st == UCT_TX_IDLE ||
             (s_q.tx_st == UCT_TX_STOP && !(i_stop_bits && !s_q.tx_stop2)));
  end

  // Next state of the whole core
  always_comb begin
    s_d = s_q;
    s_d.rx_valid = 1'b0;
    done_set = 1'b0;
    // Baud down-counter
    if (i_baud_lo_wr || baud_tick) begin
      s_d.baud_cnt = i_baud_divisor;
    end else begin
      s_d.baud_cnt = s_q.baud_cnt - 1'b1;
    end
    // Master clock toggles each tick, giving divide by two
    if (!master) begin
      s_d.xck = 1'b0;
    end else if (baud_tick) begin
      s_d.xck = ~s_q.xck;
    end
    s_d.xsync = {s_q.xsync[1:0], i_xfer_clk_in};
    s_d.rxsync = {s_q.rxsync[0], i_serial_in};
    if (baud_tick) begin
      s_d.tx_div = (s_q.tx_div == last_smp) ? '0 : s_q.tx_div + 1'b1;
    end

    // Transmitter
    if (tx_tick) begin
      case (s_q.tx_st)
        UCT_TX_IDLE, UCT_TX_STOP: begin
          if (s_q.tx_st == UCT_TX_STOP && i_stop_bits && !s_q.tx_stop2) begin
            s_d.tx_stop2 = 1'b1;
          end else if (f_valid) begin
            s_d.tx_sh = ld_word;
            s_d.tx_par = (^ld_word) ^ podd;
            s_d.txd = 1'b0;
            s_d.tx_st = UCT_TX_START;
          end else begin
            s_d.txd = UCT_LINE_IDLE;
            done_set = (s_q.tx_st == UCT_TX_STOP);
            s_d.tx_done = s_q.tx_done | done_set;
            s_d.tx_st = UCT_TX_IDLE;
          end
        end
        UCT_TX_START: begin
          s_d.txd = s_q.tx_sh[0];
          s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
          s_d.tx_cnt = 4'h1;
          s_d.tx_st = UCT_TX_DATA;
        end
        UCT_TX_DATA: begin
          if (s_q.tx_cnt == nbits) begin
            s_d.txd = pen ? s_q.tx_par : 1'b1;
            s_d.tx_stop2 = 1'b0;
            s_d.tx_st = pen ? UCT_TX_PAR : UCT_TX_STOP;
          end else begin
            s_d.txd = s_q.tx_sh[0];
            s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
            s_d.tx_cnt = s_q.tx_cnt + 1'b1;
          end
        end
        UCT_TX_PAR: begin
          s_d.txd = 1'b1;
          s_d.tx_stop2 = 1'b0;
          s_d.tx_st = UCT_TX_STOP;
        end
        default: begin
          s_d.txd = UCT_LINE_IDLE;
          s_d.tx_st = UCT_TX_IDLE;
        end
      endcase
    end
    // Clear by writing one; a completion in the same cycle wins
    if (i_tx_complete_clr && !done_set) begin
      s_d.tx_done = 1'b0;
    end

    // Receiver sample counter, async only
    if (async_mode && baud_tick) begin
      if (s_q.rx_st == UCT_RX_IDLE) begin
        s_d.rx_scnt = 4'h1;
        if (i_rx_enable && !s_q.rxsync[1]) begin
          s_d.rx_st = UCT_RX_START;
        end
      end else begin
        s_d.rx_scnt = (s_q.rx_scnt == last_smp) ? '0 : s_q.rx_scnt + 1'b1;
      end
    end
    // Sync start bit is seen on its sampling edge
    if (!async_mode && smp_edge && s_q.rx_st == UCT_RX_IDLE &&
        i_rx_enable && !s_q.rxsync[1]) begin
      s_d.rx_cnt = '0;
      s_d.rx_par = podd;
      s_d.rx_st = UCT_RX_DATA;
    end
    if (rx_evt) begin
      case (s_q.rx_st)
        UCT_RX_IDLE: begin
          // Sync start detection above owns this state; do not undo it
        end
        UCT_RX_START: begin
          // A start that is high at mid bit was noise
          s_d.rx_cnt = '0;
          s_d.rx_par = podd;
          s_d.rx_st = s_q.rxsync[1] ? UCT_RX_IDLE : UCT_RX_DATA;
        end
        UCT_RX_DATA: begin
          s_d.rx_sh = {s_q.rxsync[1], s_q.rx_sh[8:1]};
          s_d.rx_par = s_q.rx_par ^ s_q.rxsync[1];
          s_d.rx_cnt = s_q.rx_cnt + 1'b1;
          if (s_q.rx_cnt == nbits - 1'b1) begin
            s_d.rx_st = pen ? UCT_RX_PAR : UCT_RX_STOP;
          end
        end
        UCT_RX_PAR: begin
          s_d.rx_par = s_q.rx_par ^ s_q.rxsync[1];
          s_d.rx_st = UCT_RX_STOP;
        end
        UCT_RX_STOP: begin
          // Only the first stop bit is checked; a second one is never waited for
          s_d.rx_data = s_q.rx_sh >> (UCT_BITS_MAX - nbits);
          s_d.rx_fe = ~s_q.rxsync[1];
          s_d.rx_pe = pen & s_q.rx_par;
          s_d.rx_valid = 1'b1;
          s_d.rx_st = UCT_RX_IDLE;
        end
        default: begin
          s_d.rx_st = UCT_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= UCT_CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Pin control: disable waits until shifter and buffer drain
  assign o_serial_out = s_q.txd;
  assign o_serial_out_oe = i_tx_enable | (s_q.tx_st != UCT_TX_IDLE) | f_valid;
  assign o_xfer_clk_out = s_q.xck;
  assign o_xfer_clk_oe = master;
  // Status and received data
  assign o_tx_empty = ~f_valid;
  assign o_tx_complete = s_q.tx_done;
  assign o_rx_data = s_q.rx_data;
  assign o_rx_valid = s_q.rx_valid;
  assign o_rx_frame_err = s_q.rx_fe;
  assign o_rx_parity_err = s_q.rx_pe;

endmodule : uct_top

// ==== test/uct_top_sva.sv ====
`timescale 1ns/10ps

// Port-level checks on the transmit and receive sides of the core
module uct_top_sva import uct_pkg::*; (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Settings and strobes
  input wire logic i_double_speed,
  input wire logic i_sync_mode,
  input wire logic i_xck_master,
  input wire logic i_tx_enable,
  input wire logic [2:0] i_char_size,
  input wire logic [UCT_DIV_W-1:0] i_baud_divisor,
  input wire logic i_data_wr,
  input wire logic i_tx_complete_clr,
  // Observed outputs
  input wire logic o_data_ready,
  input wire logic o_tx_empty,
  input wire logic o_tx_complete,
  input wire logic [8:0] o_rx_data,
  input wire logic o_rx_valid,
  input wire logic o_rx_frame_err,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe,
  input wire logic o_xfer_clk_out,
  input wire logic o_xfer_clk_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // Accepted write must leave the buffer non-empty
  empty_clears_a: assert property (i_data_wr && o_data_ready |=> !o_tx_empty)
    else $error("tx empty still set after accepted write");
  full_not_empty_a: assert property (!o_data_ready |-> !o_tx_empty)
    else $error("buffer full yet reported empty");
  tx_owns_a: assert property (i_tx_enable |-> o_serial_out_oe)
    else $error("serial pin not driven while transmitter enabled");
  line_idle_a: assert property (!o_serial_out_oe |-> o_serial_out)
    else $error("undriven serial line not idle high");
  clk_pin_a: assert property (o_xfer_clk_oe == (i_sync_mode && i_xck_master))
    else $error("transfer clock direction wrong");
  // Master clock parks low once the pin is released
  clk_idle_a: assert property (!o_xfer_clk_oe && !$fell(o_xfer_clk_oe) |-> !o_xfer_clk_out)
    else $error("transfer clock not idle low");
  // Bit length at divisor one: 32 clocks normal, 16 double
  double_bit_a: assert property ($fell(o_serial_out) && i_double_speed && !i_sync_mode &&
      i_baud_divisor == 12'h001 |-> (!o_serial_out) [*8] ##8 !o_serial_out)
    else $error("double speed bit shorter than 16 clocks");
  normal_bit_a: assert property ($fell(o_serial_out) && !i_double_speed && !i_sync_mode &&
      i_baud_divisor == 12'h001 |-> (!o_serial_out) [*8] ##24 !o_serial_out)
    else $error("normal bit shorter than 32 clocks");
  done_idle_a: assert property ($rose(o_tx_complete) |-> o_tx_empty && o_serial_out)
    else $error("tx complete set with work pending");
  done_sticky_a: assert property (o_tx_complete && !i_tx_complete_clr |=> o_tx_complete)
    else $error("tx complete dropped without clear");
  done_clear_a: assert property (o_tx_complete && i_tx_complete_clr && o_tx_empty
      |=> !o_tx_complete)
    else $error("tx complete not cleared");
  rx_mask_a: assert property (o_rx_valid && i_char_size == 3'h0 |-> o_rx_data[8:5] == 4'h0)
    else $error("unused received bits not zero");
  rx_frame_a: assert property (o_rx_valid |-> !o_rx_frame_err)
    else $error("frame error on well formed frame");
endmodule : uct_top_sva

bind uct_top uct_top_sva i_sva (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_double_speed(i_double_speed),
  .i_sync_mode(i_sync_mode), .i_xck_master(i_xck_master), .i_tx_enable(i_tx_enable),
  .i_char_size(i_char_size), .i_baud_divisor(i_baud_divisor), .i_data_wr(i_data_wr),
  .i_tx_complete_clr(i_tx_complete_clr), .o_data_ready(o_data_ready),
  .o_tx_empty(o_tx_empty), .o_tx_complete(o_tx_complete), .o_rx_data(o_rx_data),
  .o_rx_valid(o_rx_valid), .o_rx_frame_err(o_rx_frame_err), .o_serial_out(o_serial_out),
  .o_serial_out_oe(o_serial_out_oe), .o_xfer_clk_out(o_xfer_clk_out),
  .o_xfer_clk_oe(o_xfer_clk_oe)
);

// ==== test/uct_remote_node.sv ====
`timescale 1ns/10ps

// Remote node: decodes frames off the line and echoes the line back
module uct_remote_node (
  // Clock
  input wire logic i_core_clk,
  // Line and frame format
  input wire logic i_line,
  input wire logic [7:0] i_bit_clks,
  input wire logic [3:0] i_nbits,
  input wire logic i_par_en,
  input wire logic i_stop2,
  // Echo and decoded frame
  output logic o_line_back,
  output logic [8:0] o_word,
  output logic o_par,
  output logic o_stop,
  output logic o_got
);
  // Echo gives the receive path real frames to chew on
  assign o_line_back = i_line;

  // Mid-bit sampler; a false start is dropped like a real receiver would
  initial begin
    o_word = '0;
    o_par = 1'b0;
    o_stop = 1'b0;
    o_got = 1'b0;
    forever begin
      @(negedge i_line);
      repeat (i_bit_clks / 2) @(posedge i_core_clk);
      if (i_line === 1'b0) begin
        o_word <= '0;
        o_par <= 1'b0;
        for (int i = 0; i < i_nbits; i++) begin
          repeat (i_bit_clks) @(posedge i_core_clk);
          o_word[i] <= i_line;
        end
        if (i_par_en) begin
          repeat (i_bit_clks) @(posedge i_core_clk);
          o_par <= i_line;
        end
        repeat (i_bit_clks) @(posedge i_core_clk);
        o_stop <= i_line;
        if (i_stop2) begin
          repeat (i_bit_clks) @(posedge i_core_clk);
          o_stop <= o_stop & i_line;
        end
        o_got <= 1'b1;
        @(posedge i_core_clk);
        o_got <= 1'b0;
      end
    end
  end
endmodule : uct_remote_node

// ==== test/usart_clocking_framing_tx_test.sv ====
`timescale 1ns/10ps

module usart_clocking_framing_tx_test;
  import uct_pkg::*;
  // Formats {double, stop2, parity[1:0], size[2:0]}: every bit count 5 to 9 and all parity codes
  localparam logic [6:0] CFGS [7] = '{7'h00, 7'h71, 7'h1a, 7'h4b, 7'h37, 7'h5f, 7'h04};
  // Design inputs
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_double_speed = 1'b0, i_stop_bits = 1'b0;
  logic i_tx_enable = 1'b0, i_rx_enable = 1'b0, i_baud_lo_wr = 1'b0, i_data_wr = 1'b0;
  logic i_tx_ninth = 1'b0, i_tx_complete_clr = 1'b0;
  logic i_sync_mode = 1'b0, i_xck_master = 1'b0, i_clock_polarity = 1'b0, xck_in = 1'b0;
  logic [2:0] i_char_size = 3'h0;
  logic [1:0] i_parity_mode = 2'h0;
  logic [11:0] i_baud_divisor = 12'h001;
  logic [7:0] i_data = 8'h00;
  // Design outputs and partner signals
  logic o_data_ready, o_tx_empty, o_tx_complete, o_rx_valid, o_rx_frame_err, o_rx_parity_err;
  logic o_serial_out, o_serial_out_oe, o_xfer_clk_out, o_xfer_clk_oe, line_back, got;
  logic p_par, p_stop, par_en = 1'b0;
  logic [8:0] o_rx_data, p_word;
  logic [7:0] bit_clks = 8'h20;
  logic [3:0] nbits = 4'h5;
  logic [10:0] frame_q[$];
  logic [10:0] rx_q[$];
  int failures = 0;
  int check_count = 0;

  always #25 i_core_clk = ~i_core_clk;

  uct_top #(.FIFO_DEPTH(4)) i_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_double_speed(i_double_speed),
    .i_sync_mode(i_sync_mode), .i_xck_master(i_xck_master),
    .i_clock_polarity(i_clock_polarity),
    .i_char_size(i_char_size), .i_parity_mode(i_parity_mode), .i_stop_bits(i_stop_bits),
    .i_tx_enable(i_tx_enable), .i_rx_enable(i_rx_enable), .i_baud_divisor(i_baud_divisor),
    .i_baud_lo_wr(i_baud_lo_wr), .i_data_wr(i_data_wr), .i_data(i_data),
    .i_tx_ninth(i_tx_ninth), .o_data_ready(o_data_ready), .o_tx_empty(o_tx_empty),
    .o_tx_complete(o_tx_complete), .i_tx_complete_clr(i_tx_complete_clr),
    .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .o_rx_frame_err(o_rx_frame_err),
    .o_rx_parity_err(o_rx_parity_err), .o_serial_out(o_serial_out),
    .o_serial_out_oe(o_serial_out_oe), .i_serial_in(line_back), .i_xfer_clk_in(xck_in),
    .o_xfer_clk_out(o_xfer_clk_out), .o_xfer_clk_oe(o_xfer_clk_oe)
  );

  uct_remote_node i_node (
    .i_core_clk(i_core_clk), .i_line(o_serial_out), .i_bit_clks(bit_clks),
    .i_nbits(nbits), .i_par_en(par_en), .i_stop2(i_stop_bits), .o_line_back(line_back),
    .o_word(p_word), .o_par(p_par), .o_stop(p_stop), .o_got(got)
  );

  // Slave transfer clock: eight system clocks a period, well under a quarter rate
  always begin
    repeat (4) @(posedge i_core_clk);
    xck_in <= ~xck_in;
  end

  // Shared compare
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] seen);
    check_count++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask : chk

  task automatic conclude();
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // One format: clear done flag, burst six characters into a four deep buffer
  // Mode is {sync, master, polarity}; sync bits last eight clocks at divisor three
  task automatic run_format(input logic [6:0] cfg, input logic [2:0] mode);
    int n;
    int acc;
    logic [8:0] w;
    n = (cfg[2:0] == UCT_CSZ_NINE) ? 9 : ((cfg[2:0] < 3'h4) ? 5 + cfg[2:0] : 8);
    acc = 0;
    {i_double_speed, i_stop_bits, i_parity_mode, i_char_size} <= cfg;
    nbits <= 4'(n);
    {i_sync_mode, i_xck_master, i_clock_polarity} <= mode;
    i_baud_divisor <= mode[2] ? 12'h003 : 12'h001;
    bit_clks <= mode[2] ? 8'h08 : (cfg[6] ? 8'h10 : 8'h20);
    par_en <= cfg[4];
    i_tx_complete_clr <= 1'b1;
    @(posedge i_core_clk);
    i_tx_complete_clr <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      w = 9'($urandom());
      i_data <= w[7:0];
      i_tx_ninth <= w[8];
      i_data_wr <= 1'b1;
      @(posedge i_core_clk);
      if (o_data_ready === 1'b1) begin
        acc++;
        w = w & (9'h1ff >> (9 - n));
        frame_q.push_back({1'b1, cfg[4] & (^w ^ cfg[3]), w});
        rx_q.push_back({2'b00, w});
      end
    end
    i_data_wr <= 1'b0;
    chk("refused", 11'(acc < 6), 11'h001);
    for (int t = 0; t < 3000 && o_tx_complete !== 1'b1; t++) @(posedge i_core_clk);
    chk("complete", 11'h001, {10'h000, o_tx_complete});
    repeat (4) @(posedge i_core_clk);
    chk("drained", 11'(frame_q.size() + rx_q.size()), 11'h000);
  endtask : run_format

  // Result watcher: oldest note against each decoded frame and received char
  always @(posedge i_core_clk) begin
    if (got === 1'b1) begin
      chk("frame", frame_q.size() ? frame_q.pop_front() : 11'h7ff, {p_stop, p_par, p_word});
    end
    if (o_rx_valid === 1'b1) begin
      chk("rx", rx_q.size() ? rx_q.pop_front() : 11'h7ff, {o_rx_frame_err, o_rx_parity_err, o_rx_data});
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h67a9323c));
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    i_baud_lo_wr <= 1'b1;
    i_tx_enable <= 1'b1;
    i_rx_enable <= 1'b1;
    @(posedge i_core_clk);
    i_baud_lo_wr <= 1'b0;
    for (int c = 0; c < 7; c++) begin
      run_format(CFGS[c], 3'h0);
    end
    run_format(7'h33, 3'h6);
    run_format(7'h1f, 3'h7);
    run_format(7'h0a, 3'h5);
    conclude();
  end

  // Watchdog: ten formats take well under a millisecond
  initial begin
    #3000000;
    failures++;
    conclude();
  end
endmodule : usart_clocking_framing_tx_test
